/* File: design/ett_timer.sv */
// Eight-bit timer with prescaler, four modes and two compare output channels.
// Assumes an APB master on pclk; sleep_exit pulses when leaving deep sleep.
//
// Implementation choice: register access over APB.
`timescale 1ns/1ns

// How it works
// (R01) Divider field divides tick by power of two
// (R02) Divider change alters edge rate immediately
// (R03) Clear bit zeroes counter, reads zero
// (R04) Clear bit zero after deep sleep return
// (R05) Mode 00 counts 0x00 to 0xFF
// (R06) Mode 01 counts down once to zero
// (R07) Mode 10 counts up to period, restarts
// (R08) Mode 11 counts up then down
// (R09) Channel acts when counter equals compare
// (R10) Channel 0 interrupt mask, resets one
// (R11) Channel 1 interrupt mask, resets one
// (R12) Codes set, clear, toggle; 111 unused
// (R13) Code 011 set up, clear zero/down
// (R14) Code 100 clear up, set zero/down
// (R15) Channel 0 code 101 clears at 0xFF
// (R16) Channel 0 code 110 sets at 0x00
// (R17) Channel 1 code 101 clears at period
// (R18) Channel 1 code 110 sets at period
// (R19) Channel 0 compare enable, resets zero
// (R20) Channel 1 compare enable, resets zero
// (R21) Reserved bits written 00; bit 7 zero
// (R22) Period value register, read-write, resets zero
// (R23) Start bit runs or halts counter
// (R24) Overflow flag always; irq needs both enables
// (R25) Period write waits for zero; ch1 immediate
// (R26) Up/down: ch0 and overflow flags at zero
module ett_timer (
  // APB
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        clk_en,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // System
  input  wire logic        sleep_exit,
  input  wire logic        timer_irq_enable,
  // Outputs
  output logic      [1:0]  compare_out,
  output logic             irq
);
  import ett_pkg::*;

  logic [7:0] timer_control_r;
  logic [7:0] ch_ctrl_r [2];
  logic [7:0] period_compare_value_r;
  logic [7:0] period_active_r;
  logic [7:0] channel1_compare_value_r;
  logic [7:0] count_r;
  logic       dir_down_r;
  logic       down_done_r;
  logic [6:0] prescale_r;
  logic [2:0] flags_r;
  logic [1:0] out_r;

  logic       wr;
  logic       rd;
  logic [7:0] idx;
  logic       idx_ok;
  logic       clear_wr;
  logic       tick;
  logic       started;
  logic [7:0] count_nxt;
  logic       dir_nxt;
  logic       ovf_evt;
  logic       turn_zero;
  logic [1:0] mode;
  logic [7:0] cmp_val [2];
  logic [1:0] cmp_evt;

  assign idx     = paddr[9:2];
  assign idx_ok  = (paddr[11:10] == 2'b00) && (paddr[1:0] == 2'b00);
  assign wr      = psel && penable && pwrite && clk_en;
  assign rd      = psel && !pwrite;
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !(idx_ok && (idx == TIMER_CONTROL_IDX ||
                   idx == CH0_CTRL_IDX || idx == CH0_VALUE_IDX || idx == CH1_CTRL_IDX ||
                   idx == CH1_VALUE_IDX || idx == STATUS_IDX || idx == COUNT_IDX));
  assign mode    = timer_control_r[MODE_LSB +: 2];
  assign started = timer_control_r[START_BIT];
  assign clear_wr = wr && idx_ok && idx == TIMER_CONTROL_IDX && pwdata[CLEAR_BIT]; // R03

  // Prescaler: mask picks the live divide ratio each cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prescale_r <= PRESCALE_RST;
    end else if (clk_en && started) begin
      prescale_r <= prescale_r + 7'd1;
    end
  end

  always_comb begin
    logic [6:0] mask;
    mask = 7'h7F >> (3'd7 - timer_control_r[DIV_LSB +: 3]); // R01
    tick = started && ((prescale_r & mask) == 7'h00); // R02 R23
  end

  // Counter sequencing
  always_comb begin
    count_nxt = count_r;
    dir_nxt   = dir_down_r;
    ovf_evt   = 1'b0;
    turn_zero = 1'b0;
    unique case (ett_mode_e'(mode))
      ETT_FREE: begin
        count_nxt = count_r + 8'd1; // R05
        ovf_evt   = (count_r == 8'hFE);
      end
      ETT_DOWN: begin
        if (!down_done_r) begin
          count_nxt = period_active_r; // R06
        end else if (count_r != 8'h00) begin
          count_nxt = count_r - 8'd1;
          ovf_evt   = (count_r == 8'h01);
        end
      end
      ETT_MODULO: begin
        count_nxt = (count_r >= period_active_r) ? 8'h00 : count_r + 8'd1; // R07
        ovf_evt   = (count_nxt == period_active_r);
      end
      ETT_UPDOWN: begin
        if (!dir_down_r) begin
          if (count_r >= period_active_r) begin
            dir_nxt   = 1'b1;
            count_nxt = (count_r == 8'h00) ? 8'h00 : count_r - 8'd1; // R08
          end else begin
            count_nxt = count_r + 8'd1;
          end
        end else if (count_r == 8'h00) begin
          dir_nxt   = 1'b0;
          count_nxt = 8'h01;
        end else begin
          count_nxt = count_r - 8'd1;
        end
        turn_zero = dir_nxt && count_nxt == 8'h00 || (dir_down_r && count_r == 8'h01);
        ovf_evt   = turn_zero; // R26
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_r     <= VALUE_RST;
      dir_down_r  <= 1'b0;
      down_done_r <= 1'b0;
    end else if (clk_en) begin
      if (clear_wr) begin
        count_r     <= 8'h00; // R03
        dir_down_r  <= 1'b0;
        down_done_r <= 1'b0;
      end else if (tick) begin
        count_r     <= count_nxt;
        dir_down_r  <= (mode == ETT_UPDOWN) ? dir_nxt : 1'b0;
        down_done_r <= (mode == ETT_DOWN);
      end else if (!started) begin
        down_done_r <= down_done_r && (mode == ETT_DOWN);
      end
    end
  end

  // Period shadow loads only at zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      period_active_r <= VALUE_RST;
    end else if (clk_en && count_r == 8'h00) begin
      period_active_r <= period_compare_value_r; // R25
    end
  end

  // Register writes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_control_r          <= TIMER_CONTROL_RST;
      period_compare_value_r   <= VALUE_RST;
      channel1_compare_value_r <= VALUE_RST;
    end else if (wr && idx_ok) begin
      if (idx == TIMER_CONTROL_IDX) begin
        timer_control_r <= pwdata[7:0] & ~(8'h01 << CLEAR_BIT); // R03 R04
      end
      if (idx == CH0_VALUE_IDX) begin
        period_compare_value_r <= pwdata[7:0]; // R22
      end
      if (idx == CH1_VALUE_IDX) begin
        channel1_compare_value_r <= pwdata[7:0]; // R25
      end
    end
  end

  assign cmp_val[0] = period_active_r;
  assign cmp_val[1] = channel1_compare_value_r;

  // Per-channel control and output action
  genvar c;
  generate
    for (c = 0; c < 2; c++) begin : g_ch
      logic [2:0] act;
      logic       en;
      logic       hit;
      logic       at_top;
      logic       at_zero;
      logic       down_cmp;
      assign act = ch_ctrl_r[c][ACT_LSB +: 3];
      assign en  = ch_ctrl_r[c][CMP_EN_BIT]; // R19 R20
      assign hit = tick && count_nxt == cmp_val[c] && count_nxt != count_r; // R09
      assign down_cmp = (mode == ETT_UPDOWN) && dir_nxt;
      assign at_zero  = tick && count_nxt == 8'h00 && count_r != 8'h00;
      if (c == 0) begin : g_top0
        assign at_top = tick && count_nxt == 8'hFF; // R15
      end else begin : g_top1
        assign at_top = tick && count_nxt == period_active_r; // R17 R18
      end
      // Turnaround flag only on a real counting edge, not while waiting for the next tick
      assign cmp_evt[c] = (c == 0 && mode == ETT_UPDOWN) ? tick && turn_zero : hit; // R26

      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          ch_ctrl_r[c] <= CH_CTRL_RST; // R10 R11
        end else if (wr && idx_ok && idx == (c == 0 ? CH0_CTRL_IDX : CH1_CTRL_IDX)) begin
          ch_ctrl_r[c] <= {1'b0, pwdata[6:2], 2'b00}; // R21
        end
      end

      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          out_r[c] <= 1'b0;
        end else if (clk_en && en) begin
          unique case (ett_act_e'(act))
            ETT_SET: if (hit) out_r[c] <= 1'b1; // R12
            ETT_CLR: if (hit) out_r[c] <= 1'b0;
            ETT_TOG: if (hit) out_r[c] <= ~out_r[c];
            ETT_SET_UP: begin
              if (hit) out_r[c] <= !down_cmp; // R13
              else if (at_zero && mode != ETT_UPDOWN) out_r[c] <= 1'b0;
            end
            ETT_CLR_UP: begin
              if (hit) out_r[c] <= down_cmp; // R14
              else if (at_zero && mode != ETT_UPDOWN) out_r[c] <= 1'b1;
            end
            ETT_SET_TOP: begin
              if (hit) out_r[c] <= 1'b1;
              else if (at_top) out_r[c] <= 1'b0; // R15 R17
            end
            ETT_CLR_TOP: begin
              if (hit) out_r[c] <= 1'b0;
              else if (c == 0 ? at_zero : at_top) out_r[c] <= 1'b1; // R16 R18
            end
            ETT_NONE: out_r[c] <= out_r[c];
          endcase
        end
      end
    end
  endgenerate

  assign compare_out = out_r;

  // Flags: [0] ch0, [1] ch1, [2] overflow; writing one clears, a new event wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags_r <= 3'b000;
    end else if (clk_en) begin
      flags_r <= (flags_r & ~((wr && idx_ok && idx == STATUS_IDX) ? pwdata[2:0] : 3'b000))
                 | {tick && ovf_evt, cmp_evt}; // R24
    end
  end

  assign irq = timer_irq_enable && ((flags_r[2] && timer_control_r[OVERFLOW_IRQ_MASK_BIT]) || // R24
               (flags_r[0] && ch_ctrl_r[0][IM_BIT]) || (flags_r[1] && ch_ctrl_r[1][IM_BIT]));

  // Read data from flops, one cycle after setup
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (clk_en && rd && !penable && idx_ok) begin
      unique case (idx)
        TIMER_CONTROL_IDX: prdata <= {24'h000000, timer_control_r};
        CH0_CTRL_IDX:      prdata <= {24'h000000, ch_ctrl_r[0]};
        CH0_VALUE_IDX:     prdata <= {24'h000000, period_compare_value_r};
        CH1_CTRL_IDX:      prdata <= {24'h000000, ch_ctrl_r[1]};
        CH1_VALUE_IDX:     prdata <= {24'h000000, channel1_compare_value_r};
        STATUS_IDX:        prdata <= {29'h00000000, flags_r};
        COUNT_IDX:         prdata <= {24'h000000, count_r};
        default:           prdata <= 32'h0000_0000;
      endcase
    end else if (clk_en && rd && !penable) begin
      prdata <= 32'h0000_0000;
    end
  end
endmodule // ett_timer

/* File: design/ett_pkg.sv */
// Package for the eight-bit two-channel timer: register map, fields, resets.
// Assumes a 32-bit APB slave, one register per aligned word.
package ett_pkg;
  // Printed offsets are not multiples of four: they are indexes, byte address = 4 * index
  localparam logic [7:0]  TIMER_CONTROL_IDX  = 8'hCB;
  localparam logic [7:0]  CH0_CTRL_IDX       = 8'hCC;
  localparam logic [7:0]  CH0_VALUE_IDX      = 8'hCD;
  localparam logic [7:0]  CH1_CTRL_IDX       = 8'hCE;
  localparam logic [7:0]  CH1_VALUE_IDX      = 8'hCF;
  localparam logic [7:0]  STATUS_IDX         = 8'hD0;
  localparam logic [7:0]  COUNT_IDX          = 8'hCA;
  // Timer control fields
  localparam int          DIV_LSB            = 5;
  localparam int          START_BIT          = 4;
  localparam int          OVERFLOW_IRQ_MASK_BIT          = 3;
  localparam int          CLEAR_BIT          = 2;
  localparam int          MODE_LSB           = 0;
  // Channel control fields
  localparam int          IM_BIT             = 6;
  localparam int          ACT_LSB            = 3;
  localparam int          CMP_EN_BIT         = 2;
  // Reset values
  localparam logic [7:0]  TIMER_CONTROL_RST  = 8'h08;
  localparam logic [7:0]  CH_CTRL_RST        = 8'h40;
  localparam logic [7:0]  VALUE_RST          = 8'h00;
  localparam logic [6:0]  PRESCALE_RST       = 7'h00;

  typedef enum logic [1:0] {
    ETT_FREE   = 2'b00,
    ETT_DOWN   = 2'b01,
    ETT_MODULO = 2'b10,
    ETT_UPDOWN = 2'b11
  } ett_mode_e;

  typedef enum logic [2:0] {
    ETT_SET      = 3'b000,
    ETT_CLR      = 3'b001,
    ETT_TOG      = 3'b010,
    ETT_SET_UP   = 3'b011,
    ETT_CLR_UP   = 3'b100,
    ETT_SET_TOP  = 3'b101,
    ETT_CLR_TOP  = 3'b110,
    ETT_NONE     = 3'b111
  } ett_act_e;
endpackage

/* File: test/ett_timer_props.sv */
// Assertions on the timer ports.
// Bound to every ett_timer; sees its ports only.
`timescale 1ns/1ns
module ett_props
  import ett_pkg::*;
(
  // Bus and system
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        clk_en,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        timer_irq_enable,
  // Outputs
  input wire logic [1:0]  compare_out,
  input wire logic        irq
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire logic [9:0] idx = paddr[11:2];
  wire logic       acc = psel && penable;
  wire logic       rd  = acc && !pwrite;
  wire logic       hit = paddr[1:0] == 2'h0 && idx >= {2'h0, COUNT_IDX} && idx <= {2'h0, STATUS_IDX};
  wire logic       chc = idx == {2'h0, CH0_CTRL_IDX} || idx == {2'h0, CH1_CTRL_IDX};
  a_ready_high: assert property (acc |-> pready) else $error("pready low in access");
  a_err_map: assert property (acc |-> pslverr == !hit) else $error("pslverr wrong");
  a_err_idle: assert property (!acc |-> !pslverr) else $error("pslverr outside access");
  a_miss_zero: assert property (rd && $past(clk_en) && !hit |-> prdata == 32'h0)
    else $error("gap read not zero");
  a_high_zero: assert property (rd |-> prdata[31:8] == 24'h0) else $error("upper bits set");
  a_clear_low: assert property (rd && $past(clk_en) && idx == {2'h0, TIMER_CONTROL_IDX}
    |-> !prdata[CLEAR_BIT])
    else $error("clear bit reads one");
  a_top_bit: assert property (rd && $past(clk_en) && chc |-> !prdata[7])
    else $error("channel bit 7 set");
  a_irq_gate: assert property (!timer_irq_enable |-> !irq) else $error("irq without enable");
  a_out_hold: assert property (!clk_en |=> $stable(compare_out)) else $error("output moved");
  a_reset_out: assert property ($rose(presetn) |-> compare_out == 2'h0 && !irq)
    else $error("outputs not cleared by reset");
endmodule // ett_props

bind ett_timer ett_props u_ett_props (.pclk, .presetn, .clk_en, .psel, .penable, .pwrite,
  .paddr, .prdata, .pready, .pslverr, .timer_irq_enable, .compare_out, .irq);

/* File: test/tb_ett_timer.sv */
// Testbench for ett_timer: registers, modes, channel outputs, interrupt.
// Drives the APB port itself; one clock, no partner model.
`timescale 1ns/1ns
module tb_ett_timer;
  import ett_pkg::*;
  logic        pclk = 0, presetn = 0, clk_en = 1, psel = 0, penable = 0, pwrite = 0;
  logic        sleep_exit = 0, timer_irq_enable = 0, pready, pslverr, irq;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, r;
  logic [1:0]  compare_out;
  logic [7:0]  mx;
  int          error_cnt = 0, tests_run = 0;
  localparam logic [7:0] P = 8'h06;
  always #4 pclk = ~pclk;
  ett_timer u_ett_timer (.pclk, .presetn, .clk_en, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .sleep_exit, .timer_irq_enable, .compare_out, .irq);
  task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // Request held until pready is sampled; one idle edge keeps drivers apart
  task automatic apb(logic w, logic [7:0] i, logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {2'h0, i, 2'h0};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    r = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wr(logic [7:0] i, logic [31:0] d);
    apb(1'b1, i, d);
  endtask
  task automatic rc(string nm, logic [7:0] i, logic [31:0] e);
    apb(1'b0, i, 32'h0);
    chk(nm, r, e);
  endtask
  task automatic run(logic [31:0] m);
    wr(TIMER_CONTROL_IDX, 32'h0C | m);
    wr(TIMER_CONTROL_IDX, 32'h18 | m);
  endtask
  task automatic t_reset;
    rc("ctl", TIMER_CONTROL_IDX, 32'(TIMER_CONTROL_RST));
    rc("ch0 ctl", CH0_CTRL_IDX, 32'(CH_CTRL_RST));
    rc("ch1 ctl", CH1_CTRL_IDX, 32'(CH_CTRL_RST));
    rc("period", CH0_VALUE_IDX, 32'(VALUE_RST));
    rc("count", COUNT_IDX, 32'h0);
  endtask
  task automatic t_regs;
    wr(CH0_CTRL_IDX, 32'hBC);
    rc("ch0 ctl", CH0_CTRL_IDX, 32'h3C);
    wr(CH1_CTRL_IDX, 32'hBC);
    rc("ch1 ctl", CH1_CTRL_IDX, 32'h3C);
    wr(CH0_VALUE_IDX, 32'hA5);
    rc("period", CH0_VALUE_IDX, 32'hA5);
    wr(TIMER_CONTROL_IDX, 32'hEF);
    rc("ctl", TIMER_CONTROL_IDX, 32'hEB);
    wr(8'hD1, 32'hFF);
    rc("gap", 8'hD1, 32'h0);
    sleep_exit <= 1'b1;
    @(posedge pclk);
    sleep_exit <= 1'b0;
    rc("ctl", TIMER_CONTROL_IDX, 32'hEB);
  endtask
  // Span allows for the start and stop write latency
  task automatic t_div;
    logic [31:0] h;
    for (int d = 0; d < 8; d++) begin
      run(32'(d << 5));
      repeat (200) @(posedge pclk);
      wr(TIMER_CONTROL_IDX, 32'(d << 5) | 32'h08);
      apb(1'b0, COUNT_IDX, 32'h0);
      h = r;
      chk("div", 32'(r >= (200 >> d) && r <= (208 >> d) + 1), 32'h1);
      repeat (9) @(posedge pclk);
      rc("hold", COUNT_IDX, h);
    end
    wr(TIMER_CONTROL_IDX, 32'h0C);
    rc("clear", COUNT_IDX, 32'h0);
  endtask
  // Five-cycle spacing is coprime to the modulo and up/down periods
  task automatic sweep(logic [31:0] m);
    mx = 8'h0;
    run(m);
    repeat (14) begin
      apb(1'b0, COUNT_IDX, 32'h0);
      if (r[7:0] > mx) mx = r[7:0];
      repeat (2) @(posedge pclk);
    end
  endtask
  task automatic t_modes;
    wr(CH0_VALUE_IDX, 32'(P));
    sweep(32'h0);
    chk("free", 32'(mx > P), 32'h1);
    sweep(32'h2);
    chk("modulo", 32'(mx), 32'(P));
    sweep(32'h3);
    chk("updown", 32'(mx), 32'(P));
    run(32'h1);
    apb(1'b0, COUNT_IDX, 32'h0);
    chk("down", 32'(r != 0 && r <= P), 32'h1);
    repeat (20) @(posedge pclk);
    rc("down end", COUNT_IDX, 32'h0);
  endtask
  task automatic t_cmp;
    logic [7:0] cc [8] = '{8'h04, 8'h0C, 8'h00, 8'h14, 8'h1C, 8'h24, 8'h2C, 8'h34};
    logic [1:0] ex [8] = '{2'b10, 2'b01, 2'b01, 2'b11, 2'b11, 2'b11, 2'b11, 2'b11};
    logic [1:0] s;
    wr(CH1_VALUE_IDX, 32'h3);
    wr(CH0_CTRL_IDX, 32'h44);
    run(32'h2);
    for (int k = 0; k < 8; k++) begin
      wr(CH1_CTRL_IDX, 32'(cc[k]) | 32'h40);
      repeat (10) @(posedge pclk);
      s = 2'b00;
      repeat (14) begin
        @(negedge pclk);
        s = s | {compare_out[1] === 1'b1, compare_out[1] === 1'b0};
      end
      @(posedge pclk);
      chk("ch1 out", 32'(s), 32'(ex[k]));
    end
    chk("ch0 out", 32'(compare_out[0]), 32'h1);
  endtask
  task automatic t_irq;
    rc("ovf flag", STATUS_IDX, 32'h7);
    chk("irq off", 32'(irq), 32'h0);
    timer_irq_enable <= 1'b1;
    repeat (2) @(posedge pclk);
    chk("irq on", 32'(irq), 32'h1);
    wr(TIMER_CONTROL_IDX, 32'h02);
    wr(CH0_CTRL_IDX, 32'h04);
    wr(CH1_CTRL_IDX, 32'h04);
    wr(STATUS_IDX, 32'h7);
    rc("flags clr", STATUS_IDX, 32'h0);
    chk("irq clr", 32'(irq), 32'h0);
    wr(TIMER_CONTROL_IDX, 32'h12);
    repeat (20) @(posedge pclk);
    chk("irq mask", 32'(irq), 32'h0);
    wr(TIMER_CONTROL_IDX, 32'h1A);
    chk("irq unmask", 32'(irq), 32'h1);
    clk_en <= 1'b0;
    repeat (5) @(posedge pclk);
    clk_en <= 1'b1;
    @(posedge pclk);
  endtask
  // Up/down: code 011 clears on the way down, so half of each 12-tick period is high
  task automatic t_updown;
    logic [7:0] hi;
    wr(CH1_CTRL_IDX, 32'h1C);
    run(32'h3);
    repeat (14) @(posedge pclk);
    hi = 8'h0;
    repeat (24) begin
      @(negedge pclk);
      hi = hi + 8'(compare_out[1] === 1'b1);
    end
    @(posedge pclk);
    chk("ud ch1 high", 32'(hi), 32'd12);
    wr(CH0_VALUE_IDX, 32'h40);
    run(32'h3);
    wr(STATUS_IDX, 32'h7);
    repeat (80) @(posedge pclk);
    apb(1'b0, STATUS_IDX, 32'h0);
    chk("ud no ch0 flag", r & 32'h5, 32'h0);
    repeat (60) @(posedge pclk);
    apb(1'b0, STATUS_IDX, 32'h0);
    chk("ud zero flags", r & 32'h5, 32'h5);
  endtask
  // Free mode, ch0 code 101: low after passing 0xFF, high again past the period
  task automatic t_top;
    wr(CH0_CTRL_IDX, 32'h2C);
    run(32'h0);
    repeat (270) @(posedge pclk);
    @(negedge pclk);
    chk("ch0 top clr", 32'(compare_out[0]), 32'h0);
    repeat (100) @(posedge pclk);
    @(negedge pclk);
    chk("ch0 top set", 32'(compare_out[0]), 32'h1);
    @(posedge pclk);
  endtask
  task automatic test_done;
    $display("checks %0d errors %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset;
    t_regs;
    t_div;
    t_modes;
    t_cmp;
    t_irq;
    t_updown;
    t_top;
    test_done;
  end
  initial begin
    repeat (30000) @(posedge pclk);
    error_cnt++;
    test_done;
  end
endmodule // tb_ett_timer
